// file: shared/asf_pkg.sv
package asf_pkg;

	// ------------------------------------------------------------
	// Register map
	// ------------------------------------------------------------
	localparam logic [11:0] ASF_STATUS_OFS = 12'h030;
	localparam logic [31:0] ASF_STATUS_RST = 32'h0000_0000;

	// ------------------------------------------------------------
	// Field positions in converter_status
	// ------------------------------------------------------------
	localparam int ASF_B_Q_HALF = 30;
	localparam int ASF_B_Q_OV = 29;
	localparam int ASF_B_Q_EMPTY = 28;
	localparam int ASF_B_Q_FULL = 27;
	localparam int ASF_B_CMP1 = 26;
	localparam int ASF_B_CMP0 = 25;
	localparam int ASF_B_CONV_END = 24;
	localparam int ASF_B_QI_HALF = 22;
	localparam int ASF_B_QI_OV = 21;
	localparam int ASF_B_QI_EMPTY = 20;
	localparam int ASF_B_QI_FULL = 19;
	localparam int ASF_B_ONE_CH = 18;
	localparam int ASF_B_CLR_SEL = 17;
	localparam int ASF_B_LOST = 16;
	localparam int ASF_B_M_CMP1 = 15;
	localparam int ASF_B_M_CMP0 = 14;
	localparam int ASF_B_M_CONV = 13;
	localparam int ASF_B_M_HALF = 12;
	localparam int ASF_B_M_OV = 11;
	localparam int ASF_B_M_EMPTY = 10;
	localparam int ASF_B_M_FULL = 9;
	localparam int ASF_B_VALID = 8;
	localparam int ASF_B_CHAN_LO = 4;
	localparam int ASF_B_BUSY = 3;
	localparam int ASF_B_CMPI1 = 2;
	localparam int ASF_B_CMPI0 = 1;
	localparam int ASF_B_CONVI = 0;

	// ------------------------------------------------------------
	// Widths
	// ------------------------------------------------------------
	localparam int ASF_RES_W = 12;
	localparam int ASF_CHAN_W = 4;
	localparam int ASF_MCNT_W = 4;
	localparam logic [ASF_MCNT_W:0] ASF_CNT_ZERO = 5'h00;
	localparam logic [ASF_MCNT_W:0] ASF_CNT_ONE = 5'h01;

	// ------------------------------------------------------------
	// Carriers
	// ------------------------------------------------------------
	typedef struct packed {
		logic enable;
		logic irq_enable;
		logic cond_ge;
		logic [ASF_CHAN_W-1:0] chan;
		logic [ASF_MCNT_W-1:0] match_count_setting;
		logic [ASF_RES_W-1:0] level;
	} asf_cmp_cfg_s;

	typedef struct packed {
		logic valid;
		logic [ASF_CHAN_W-1:0] chan;
		logic [ASF_RES_W-1:0] data;
	} asf_result_s;

	typedef struct packed {
		logic half;
		logic full;
		logic empty;
		logic overflow;
	} asf_queue_s;

endpackage

// file: rtl/asf_cmp_unit.sv
`timescale 1ns/1ns
`default_nettype none
module asf_cmp_unit
	import asf_pkg::*;
(
	input wire logic core_clk,
	input wire logic srst,
	input wire asf_cmp_cfg_s cfg,
	input wire asf_result_s result,
	output logic hit
);

	// ------------------------------------------------------------
	// Match detection
	// ------------------------------------------------------------
	logic match;
	logic [ASF_MCNT_W:0] cnt_reg;
	logic [ASF_MCNT_W:0] cnt_next;
	logic last;

	always_comb begin
		match = 1'b0;
		if (cfg.enable && result.valid && result.chan == cfg.chan) begin
			if (cfg.cond_ge)
				match = result.data >= cfg.level;
			else
				match = result.data < cfg.level;
		end
	end

	// Flag fires on the (setting+1)-th match, then counting restarts
	assign last = cnt_reg == {1'b0, cfg.match_count_setting};
	assign cnt_next = cnt_reg + ASF_CNT_ONE;

	// ------------------------------------------------------------
	// Counter
	// ------------------------------------------------------------
	always_ff @(posedge core_clk) begin
		if (srst || !cfg.enable)
			cnt_reg <= ASF_CNT_ZERO;
		else if (match)
			cnt_reg <= last ? ASF_CNT_ZERO : cnt_next;
	end

	always_ff @(posedge core_clk) begin
		if (srst)
			hit <= 1'b0;
		else
			hit <= match && last;
	end

endmodule // asf_cmp_unit
`default_nettype wire

// file: rtl/asf_status.sv
`timescale 1ns/1ns
`default_nettype none
module asf_status
	import asf_pkg::*;
(
	input wire logic core_clk,
	input wire logic srst,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	output logic irq,
	input wire logic conv_done,
	input wire logic one_ch_mode,
	input wire logic software_conv_trigger,
	input wire logic data_lost_mirror,
	input wire logic data_valid_mirror,
	input wire logic [ASF_CHAN_W-1:0] cur_chan,
	input wire logic [ASF_CHAN_W-1:0] next_chan,
	input wire asf_result_s result,
	input wire asf_queue_s queue,
	input wire asf_cmp_cfg_s cmp0_cfg,
	input wire asf_cmp_cfg_s cmp1_cfg
);

	// ------------------------------------------------------------
	// Bus decode
	// ------------------------------------------------------------
	logic addr_hit;
	logic wr_fire;
	logic rd_setup;
	logic [31:0] lane_mask;
	logic [31:0] w1c;

	assign addr_hit = paddr == ASF_STATUS_OFS;
	// Zero wait states: every access completes in its first access cycle
	assign pready = 1'b1;
	assign pslverr = psel && penable && !addr_hit;
	assign wr_fire = psel && penable && pwrite && addr_hit;
	assign rd_setup = psel && !penable && !pwrite;
	assign lane_mask = {{8{pstrb[3]}}, {8{pstrb[2]}},
		{8{pstrb[1]}}, {8{pstrb[0]}}};
	// Only ones written through enabled lanes clear a flag
	assign w1c = wr_fire ? (pwdata & lane_mask) : 32'h0000_0000;

	// ------------------------------------------------------------
	// Event sources
	// ------------------------------------------------------------
	logic half_prev_reg;
	logic full_prev_reg;
	logic empty_prev_reg;
	logic busy_prev_reg;
	logic ev_half;
	logic ev_full;
	logic ev_empty;
	logic ev_ov;
	logic ev_start;
	logic hit0;
	logic hit1;

	always_ff @(posedge core_clk) begin
		if (srst) begin
			half_prev_reg <= 1'b0;
			full_prev_reg <= 1'b0;
			empty_prev_reg <= 1'b0;
			busy_prev_reg <= 1'b0;
		end else begin
			half_prev_reg <= queue.half;
			full_prev_reg <= queue.full;
			empty_prev_reg <= queue.empty;
			busy_prev_reg <= software_conv_trigger;
		end
	end

	// Half, full and empty flag on entry only, so a long stay does not refire; overflow sets every cycle it is high
	assign ev_half = queue.half && !half_prev_reg;
	assign ev_full = queue.full && !full_prev_reg;
	assign ev_empty = queue.empty && !empty_prev_reg;
	assign ev_ov = queue.overflow;
	assign ev_start = software_conv_trigger && !busy_prev_reg;

	asf_cmp_unit u_cmp0 (
		.core_clk(core_clk),
		.srst(srst),
		.cfg(cmp0_cfg),
		.result(result),
		.hit(hit0)
	);

	asf_cmp_unit u_cmp1 (
		.core_clk(core_clk),
		.srst(srst),
		.cfg(cmp1_cfg),
		.result(result),
		.hit(hit1)
	);

	// ------------------------------------------------------------
	// Queue status flags
	// ------------------------------------------------------------
	logic q_half_reg;
	logic q_ov_reg;
	logic q_empty_reg;
	logic q_full_reg;

	// A set in the same cycle as a clear wins
	always_ff @(posedge core_clk) begin
		if (srst) begin
			q_half_reg <= ASF_STATUS_RST[ASF_B_Q_HALF];
			q_ov_reg <= ASF_STATUS_RST[ASF_B_Q_OV];
			q_empty_reg <= ASF_STATUS_RST[ASF_B_Q_EMPTY];
			q_full_reg <= ASF_STATUS_RST[ASF_B_Q_FULL];
		end else begin
			q_half_reg <= (q_half_reg && !w1c[ASF_B_Q_HALF])
				|| ev_half;
			q_ov_reg <= (q_ov_reg && !w1c[ASF_B_Q_OV])
				|| ev_ov;
			q_empty_reg <= (q_empty_reg && !w1c[ASF_B_Q_EMPTY])
				|| ev_empty;
			q_full_reg <= (q_full_reg && !w1c[ASF_B_Q_FULL])
				|| ev_full;
		end
	end

	// ------------------------------------------------------------
	// Queue interrupt flags
	// ------------------------------------------------------------
	logic qi_half_reg;
	logic qi_ov_reg;
	logic qi_empty_reg;
	logic qi_full_reg;

	always_ff @(posedge core_clk) begin
		if (srst) begin
			qi_half_reg <= ASF_STATUS_RST[ASF_B_QI_HALF];
			qi_ov_reg <= ASF_STATUS_RST[ASF_B_QI_OV];
			qi_empty_reg <= ASF_STATUS_RST[ASF_B_QI_EMPTY];
			qi_full_reg <= ASF_STATUS_RST[ASF_B_QI_FULL];
		end else begin
			qi_half_reg <= (qi_half_reg && !w1c[ASF_B_QI_HALF])
				|| ev_half;
			qi_ov_reg <= (qi_ov_reg && !w1c[ASF_B_QI_OV])
				|| ev_ov;
			qi_empty_reg <= (qi_empty_reg && !w1c[ASF_B_QI_EMPTY])
				|| ev_empty;
			qi_full_reg <= (qi_full_reg && !w1c[ASF_B_QI_FULL])
				|| ev_full;
		end
	end

	// ------------------------------------------------------------
	// Conversion end flags
	// ------------------------------------------------------------
	logic conv_end_reg;
	logic convi_reg;

	always_ff @(posedge core_clk) begin
		if (srst) begin
			conv_end_reg <= ASF_STATUS_RST[ASF_B_CONV_END];
			convi_reg <= ASF_STATUS_RST[ASF_B_CONVI];
		end else begin
			conv_end_reg <= (conv_end_reg && !w1c[ASF_B_CONV_END])
				|| conv_done;
			convi_reg <= (convi_reg && !w1c[ASF_B_CONVI])
				|| conv_done;
		end
	end

	// ------------------------------------------------------------
	// Compare flags
	// ------------------------------------------------------------
	logic cmp1_reg;
	logic cmp0_reg;
	logic cmpi1_reg;
	logic cmpi0_reg;

	always_ff @(posedge core_clk) begin
		if (srst) begin
			cmp1_reg <= ASF_STATUS_RST[ASF_B_CMP1];
			cmp0_reg <= ASF_STATUS_RST[ASF_B_CMP0];
		end else begin
			cmp1_reg <= (cmp1_reg && !w1c[ASF_B_CMP1])
				|| hit1;
			cmp0_reg <= (cmp0_reg && !w1c[ASF_B_CMP0])
				|| hit0;
		end
	end

	// Interrupt flags only latch matches whose unit allows a request
	always_ff @(posedge core_clk) begin
		if (srst) begin
			cmpi1_reg <= ASF_STATUS_RST[ASF_B_CMPI1];
			cmpi0_reg <= ASF_STATUS_RST[ASF_B_CMPI0];
		end else begin
			cmpi1_reg <= (cmpi1_reg && !w1c[ASF_B_CMPI1])
				|| (hit1 && cmp1_cfg.irq_enable);
			cmpi0_reg <= (cmpi0_reg && !w1c[ASF_B_CMPI0])
				|| (hit0 && cmp0_cfg.irq_enable);
		end
	end

	// ------------------------------------------------------------
	// Single channel sequence done
	// ------------------------------------------------------------
	logic one_ch_reg;
	logic clr_sel_reg;
	logic one_ch_clr;

	// Hardware clearing drops the flag when the next conversion starts
	assign one_ch_clr = clr_sel_reg ? ev_start
		: w1c[ASF_B_ONE_CH];

	always_ff @(posedge core_clk) begin
		if (srst)
			one_ch_reg <= ASF_STATUS_RST[ASF_B_ONE_CH];
		else
			one_ch_reg <= (one_ch_reg && !one_ch_clr)
				|| (conv_done && one_ch_mode);
	end

	// ------------------------------------------------------------
	// Writable control bits
	// ------------------------------------------------------------
	logic [6:0] mask_reg;
	logic [6:0] mask_wr;

	assign mask_wr = pwdata[ASF_B_M_CMP1:ASF_B_M_FULL];

	always_ff @(posedge core_clk) begin
		if (srst)
			clr_sel_reg <= ASF_STATUS_RST[ASF_B_CLR_SEL];
		else if (wr_fire && pstrb[2])
			clr_sel_reg <= pwdata[ASF_B_CLR_SEL];
	end

	// All seven masks sit in byte lane one (bits 15:8), so only that
	// strobe may change them; a lane-zero write must leave them alone
	always_ff @(posedge core_clk) begin
		if (srst) begin
			mask_reg <= ASF_STATUS_RST[ASF_B_M_CMP1:ASF_B_M_FULL];
		end else if (wr_fire && pstrb[1]) begin
			mask_reg <= mask_wr;
		end
	end

	// ------------------------------------------------------------
	// Interrupt output
	// ------------------------------------------------------------
	logic [6:0] irq_src;

	// A mask bit of one lets its source through; zero blocks it
	assign irq_src = {cmpi1_reg, cmpi0_reg, convi_reg,
		qi_half_reg, qi_ov_reg, qi_empty_reg, qi_full_reg};

	always_ff @(posedge core_clk) begin
		if (srst)
			irq <= 1'b0;
		else
			irq <= |(irq_src & mask_reg);
	end

	// ------------------------------------------------------------
	// Read path
	// ------------------------------------------------------------
	logic [31:0] status_word;
	logic [ASF_CHAN_W-1:0] chan_view;

	assign chan_view = software_conv_trigger ? cur_chan
		: next_chan;

	// Mirrors are built from live inputs, so writes cannot reach them
	always_comb begin
		status_word = 32'h0000_0000;
		status_word[ASF_B_Q_HALF] = q_half_reg;
		status_word[ASF_B_Q_OV] = q_ov_reg;
		status_word[ASF_B_Q_EMPTY] = q_empty_reg;
		status_word[ASF_B_Q_FULL] = q_full_reg;
		status_word[ASF_B_CMP1] = cmp1_reg;
		status_word[ASF_B_CMP0] = cmp0_reg;
		status_word[ASF_B_CONV_END] = conv_end_reg;
		status_word[ASF_B_QI_HALF] = qi_half_reg;
		status_word[ASF_B_QI_OV] = qi_ov_reg;
		status_word[ASF_B_QI_EMPTY] = qi_empty_reg;
		status_word[ASF_B_QI_FULL] = qi_full_reg;
		status_word[ASF_B_ONE_CH] = one_ch_reg;
		status_word[ASF_B_CLR_SEL] = clr_sel_reg;
		status_word[ASF_B_LOST] = data_lost_mirror;
		status_word[ASF_B_M_CMP1:ASF_B_M_FULL] = mask_reg;
		status_word[ASF_B_VALID] = data_valid_mirror;
		status_word[ASF_B_CHAN_LO+:ASF_CHAN_W] = chan_view;
		status_word[ASF_B_BUSY] = software_conv_trigger;
		status_word[ASF_B_CMPI1] = cmpi1_reg;
		status_word[ASF_B_CMPI0] = cmpi0_reg;
		status_word[ASF_B_CONVI] = convi_reg;
	end

	// Sampled in the setup cycle so data stands through the access cycle
	always_ff @(posedge core_clk) begin
		if (srst)
			prdata <= 32'h0000_0000;
		else if (rd_setup)
			prdata <= addr_hit ? status_word : 32'h0000_0000;
	end

endmodule // asf_status
`default_nettype wire

// file: dv/asf_status_sva.sv
`timescale 1ns/1ns
`default_nettype none
module asf_status_sva
	import asf_pkg::*;
(
	input wire logic core_clk,
	input wire logic srst,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic irq,
	input wire logic conv_done,
	input wire logic one_ch_mode,
	input wire logic software_conv_trigger,
	input wire logic data_lost_mirror,
	input wire logic data_valid_mirror,
	input wire logic [ASF_CHAN_W-1:0] cur_chan,
	input wire logic [ASF_CHAN_W-1:0] next_chan,
	input wire asf_result_s result,
	input wire asf_queue_s queue,
	input wire asf_cmp_cfg_s cmp0_cfg,
	input wire asf_cmp_cfg_s cmp1_cfg
);
	// --------
	// Checks
	// --------
	default clocking @(posedge core_clk); endclocking
	default disable iff (srst);
	logic rd_set;
	logic rd_ok;
	assign rd_set = psel && !penable && !pwrite;
	assign rd_ok = rd_set && paddr == ASF_STATUS_OFS;
	chk_bad_addr: assert property (
		psel && penable && paddr != ASF_STATUS_OFS |-> pslverr)
		else $error("no slave error on unmapped access");
	chk_unmapped_rd: assert property (
		rd_set && paddr != ASF_STATUS_OFS |=> prdata == 32'h0)
		else $error("unmapped read not zero");
	chk_rsvd_zero: assert property (
		rd_ok |=> !prdata[31] && !prdata[23])
		else $error("reserved bit set");
	chk_lost_copy: assert property (
		rd_ok |=> prdata[16] == $past(data_lost_mirror))
		else $error("overrun copy wrong");
	chk_valid_copy: assert property (
		rd_ok |=> prdata[8] == $past(data_valid_mirror))
		else $error("valid copy wrong");
	chk_chan_field: assert property (
		rd_ok |=> prdata[7:4] == ($past(software_conv_trigger) ?
		$past(cur_chan) : $past(next_chan)))
		else $error("channel field wrong");
	chk_busy_copy: assert property (
		rd_ok |=> prdata[3] == $past(software_conv_trigger))
		else $error("busy copy wrong");
	chk_reset_clear: assert property (
		$past(srst) |-> prdata == 32'h0 && !irq)
		else $error("state not cleared by reset");
	chk_irq_mask: assert property (
		rd_ok |=> irq == |(prdata[15:9] & {prdata[2:0], prdata[22:19]}))
		else $error("irq disagrees with flags and masks");
	cover property (rd_set && paddr != ASF_STATUS_OFS);
	cover property ($rose(irq));
	cover property (conv_done && one_ch_mode);
	cover property (result.valid && cmp0_cfg.enable);
endmodule // asf_status_sva
`default_nettype wire

// file: dv/asf_status_tb.sv
`timescale 1ns/1ns
`default_nettype none
module asf_status_tb import asf_pkg::*;;
	// --------
	// Bench
	// --------
	logic core_clk, srst, psel, penable, pwrite, conv_done, one_ch_mode;
	logic trig, lost, vld, pready, pslverr, irq;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rd, f, seed;
	logic [3:0] pstrb, cur, nxt;
	asf_result_s result;
	asf_queue_s queue;
	asf_cmp_cfg_s cmp0_cfg, cmp1_cfg;
	int error_cnt, comparisons, c0, c1, b;
	int sb[4] = '{29, 28, 27, 30};
	asf_status dut(.core_clk(core_clk), .srst(srst), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .irq(irq), .conv_done(conv_done),
		.one_ch_mode(one_ch_mode), .software_conv_trigger(trig),
		.data_lost_mirror(lost), .data_valid_mirror(vld),
		.cur_chan(cur), .next_chan(nxt), .result(result), .queue(queue),
		.cmp0_cfg(cmp0_cfg), .cmp1_cfg(cmp1_cfg));
	always #50 core_clk = ~core_clk;
	function automatic logic [31:0] xs(input logic [31:0] s);
		s ^= s << 13;
		s ^= s >> 17;
		s ^= s << 5;
		return s;
	endfunction
	task chk(input logic [31:0] s, input logic [31:0] e);
		comparisons++;
		if (s !== e) begin
			error_cnt++;
			$display("[FAIL] t=%0t got %h exp %h", $time, s, e);
		end
	endtask
	task test_done;
		$display("errors %0d comparisons %0d", error_cnt, comparisons);
		if (error_cnt == 0 && comparisons > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int n;
		logic [31:0] clr;
		logic [31:0] lm;
		@(posedge core_clk);
		psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
		@(posedge core_clk);
		penable <= 1;
		n = 0;
		do begin
			@(posedge core_clk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		if (n >= 50) begin
			error_cnt++;
			test_done;
		end
		rd = prdata;
		psel <= 0;
		penable <= 0;
		chk({31'h0, pslverr}, {31'h0, a != ASF_STATUS_OFS});
		// Model: only enabled lanes count; bit 18 is kept while
		// hardware clearing is selected
		lm = {{8{pstrb[3]}}, {8{pstrb[2]}}, {8{pstrb[1]}}, {8{pstrb[0]}}};
		clr = d & lm & 32'h7f7c0007;
		lm &= 32'h0002fe00;
		if (f[17]) clr[18] = 0;
		if (w && a == ASF_STATUS_OFS)
			f = (f & ~clr & ~lm) | (d & lm);
	endtask
	task rdc;
		apb(0, ASF_STATUS_OFS, 0);
		chk(rd, f | {lost, 7'h0, vld, trig ? cur : nxt, trig, 3'h0});
		chk({31'h0, irq}, {31'h0, |(f[15:9] & {f[2:0], f[22:19]})});
	endtask
	task conv;
		@(posedge core_clk) conv_done <= 1;
		@(posedge core_clk) conv_done <= 0;
		f[24] = 1;
		f[0] = 1;
		if (one_ch_mode) f[18] = 1;
	endtask
	// Unit model: only results on its channel count, misses keep the count
	task upd(input asf_cmp_cfg_s c, inout int n, input int fb, input int ib);
		if (c.enable && result.chan == c.chan && (c.cond_ge ?
			result.data >= c.level : result.data < c.level)) n++;
		if (n == c.match_count_setting + 1) begin
			n = 0;
			f[fb] = 1;
			if (c.irq_enable) f[ib] = 1;
		end
	endtask
	initial begin
		core_clk = 0; srst = 1; psel = 0; penable = 0; pwrite = 0;
		paddr = 0; pwdata = 0; pstrb = 4'hf; conv_done = 0; one_ch_mode = 0;
		trig = 0; lost = 0; vld = 0; cur = 0; nxt = 0; result = '0;
		queue = '0; f = 0; seed = 32'hc5d6; c0 = 0; c1 = 0;
		cmp0_cfg = '{1'b1, 1'b1, 1'b1, 4'h3, 4'h1, 12'h800};
		cmp1_cfg = '{1'b1, 1'b0, 1'b0, 4'h3, 4'h2, 12'h400};
		repeat (6) @(posedge core_clk);
		srst <= 0;
		rdc;
		apb(1, 12'h034, 32'hffffffff);
		apb(0, 12'h034, 0);
		chk(rd, 0);
		for (b = 0; b < 4; b++) begin
			seed = xs(seed);
			{nxt, cur, trig, vld, lost} <= seed[10:0];
			apb(1, ASF_STATUS_OFS, 32'h000101f8);
			rdc;
		end
		trig <= 0;
		apb(1, ASF_STATUS_OFS, 32'h00003e00);
		conv;
		rdc;
		apb(1, ASF_STATUS_OFS, 32'h00003e00);
		rdc;
		apb(1, ASF_STATUS_OFS, 32'h01003e01);
		rdc;
		for (b = 0; b < 4; b++) begin
			@(posedge core_clk) queue <= asf_queue_s'(4'h1 << b);
			@(posedge core_clk) queue <= '0;
			f[sb[b]] = 1;
			f[sb[b] - 8] = 1;
			rdc;
			apb(1, ASF_STATUS_OFS, (32'h1 << sb[b])
				| (32'h1 << (sb[b] - 8)) | 32'h1e00);
			rdc;
		end
		one_ch_mode <= 1;
		conv;
		rdc;
		apb(1, ASF_STATUS_OFS, 32'h00020000);
		apb(1, ASF_STATUS_OFS, 32'h00060000);
		rdc;
		@(posedge core_clk) trig <= 1;
		@(posedge core_clk);
		f[18] = 0;
		rdc;
		trig <= 0;
		one_ch_mode <= 0;
		apb(1, ASF_STATUS_OFS, 32'h0100c001);
		// A lane-zero write must not reach the masks in lane one
		pstrb <= 4'h1;
		apb(1, ASF_STATUS_OFS, 32'h0000fe00);
		rdc;
		pstrb <= 4'hf;
		for (b = 0; b < 16; b++) begin
			seed = xs(seed);
			@(posedge core_clk) result <= '{1'b1, seed[12] ? 4'h3 : 4'h5,
				seed[11:0]};
			@(posedge core_clk) result.valid <= 0;
			upd(cmp0_cfg, c0, 25, 1);
			upd(cmp1_cfg, c1, 26, 2);
			@(posedge core_clk);
			rdc;
		end
		test_done;
	end
	initial begin
		repeat (20000) @(posedge core_clk);
		error_cnt++;
		test_done;
	end
endmodule // asf_status_tb
bind asf_status asf_status_sva chk_i(.core_clk(core_clk), .srst(srst),
	.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
	.pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
	.pslverr(pslverr), .irq(irq), .conv_done(conv_done),
	.one_ch_mode(one_ch_mode), .software_conv_trigger(software_conv_trigger),
	.data_lost_mirror(data_lost_mirror), .data_valid_mirror(data_valid_mirror),
	.cur_chan(cur_chan), .next_chan(next_chan), .result(result),
	.queue(queue), .cmp0_cfg(cmp0_cfg), .cmp1_cfg(cmp1_cfg));
`default_nettype wire
